// ---- core/two_wire_defs.vh ----
`ifndef TWO_WIRE_DEFS_VH
`define TWO_WIRE_DEFS_VH

// ****************************************
// Slave addresses and byte framing
// ****************************************
`define SLAVE_ADDR_DEFAULT 8'h90
`define SLAVE_ADDR_ALT     8'hBA
`define DIR_READ           1'b1
`define BITS_PER_BYTE      4'h8
`define BIT_COUNT_ZERO     4'h0
`define BIT_COUNT_ONE      4'h1

// ****************************************
// Register store geometry
// ****************************************
`define REG_INDEX_BITS     8
`define REG_DEPTH          256
`define REG_DATA_BITS      16
`define REG_ADDR_STEP      16'h0001

// ****************************************
// Message byte positions within a write
// ****************************************
`define MSG_ADDR_HI        2'h0
`define MSG_ADDR_LO        2'h1
`define MSG_DATA_HI        2'h2
`define MSG_DATA_LO        2'h3

`endif

// ---- core/reg_store.v ----
`timescale 1ns/1ps
`include "two_wire_defs.vh"

module reg_store
(
   input  wire                          mclk,
   input  wire                          we,
   input  wire [`REG_INDEX_BITS-1:0]    waddr,
   input  wire [`REG_DATA_BITS-1:0]     wdata,
   input  wire [`REG_INDEX_BITS-1:0]    raddr,
   output reg  [`REG_DATA_BITS-1:0]     rdata
);

   // ****************************************
   // Storage
   // ****************************************
   // No reset on the array; contents are undefined until first written.
   reg [`REG_DATA_BITS-1:0] mem [0:`REG_DEPTH-1];

   always @(posedge mclk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule

// ---- core/two_wire_register_slave.v ----
`timescale 1ns/1ps
`include "two_wire_defs.vh"

// Functional notes
// - Address 0x90 when select low, 0xBA high.
// - Write address even, read address plus one.
// - First byte: bits 7-1 address, bit 0 direction.
// - Bus idle when clock and data high.
// - Slave only detects start and stop.
// - Start begins decoding, stop returns idle.
// - Start: data falls while clock high.
// - Repeated start restarts address decoding.
// - Stop: data rises while clock high.
// - Eight bits per byte, MSB first.
// - One bit per clock, change while low.
// - Receiver pulls data low to acknowledge.
// - Transmit role decides who releases during acknowledge.
// - Master no-acknowledge ends read, slave releases.
// - Message bytes: register address, data.
// - Write: address high, low, data high, low.
// - Random read via repeated start read.
// - Plain read uses last written address.
// - Acknowledged bytes continue sequential transfer.

module two_wire_register_slave
(
   input  wire                          mclk,
   input  wire                          rst,
   input  wire                          serial_clock_line,
   input  wire                          serial_data_in,
   output wire                          serial_data_out,
   output wire                          serial_data_oe,
   input  wire                          address_select_pin,
   output reg                           reg_write,
   output reg  [15:0]                   reg_write_addr,
   output reg  [15:0]                   reg_write_data,
   output reg                           bus_busy
);

   // ****************************************
   // States
   // ****************************************
   localparam [2:0] S_IDLE   = 3'h0;
   localparam [2:0] S_RX     = 3'h1;
   localparam [2:0] S_ACK    = 3'h2;
   localparam [2:0] S_TX     = 3'h3;
   localparam [2:0] S_MACK   = 3'h4;
   localparam [2:0] S_TXLOAD = 3'h5;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Three stages each; a level is taken once stages two and three agree,
   // which also rejects single-sample glitches on the slow bus lines.
   reg  [2:0]  scl_sync;
   reg  [2:0]  sda_sync;
   reg  [2:0]  sel_sync;
   reg         scl_f;
   reg         sda_f;
   reg         sel_f;
   reg         scl_d;
   reg         sda_d;

   always @(posedge mclk)
   begin
      if (rst)
      begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         sel_sync <= 3'h0;
         scl_f    <= 1'b1;
         sda_f    <= 1'b1;
         sel_f    <= 1'b0;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
      end
      else
      begin
         scl_sync <= {scl_sync[1:0], serial_clock_line};
         sda_sync <= {sda_sync[1:0], serial_data_in};
         sel_sync <= {sel_sync[1:0], address_select_pin};
         scl_f    <= (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_f;
         sda_f    <= (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
         sel_f    <= (sel_sync[1] == sel_sync[2]) ? sel_sync[2] : sel_f;
         scl_d <= scl_f;
         sda_d <= sda_f;
      end
   end

   wire scl_rise   = scl_f & ~scl_d;
   wire scl_fall   = ~scl_f & scl_d;
   wire start_det  = scl_f & scl_d & sda_d & ~sda_f;
   wire stop_det   = scl_f & scl_d & ~sda_d & sda_f;

   // ****************************************
   // Address decode
   // ****************************************
   function addr_match;
      input [7:0] rx_byte;
      input       sel;
      reg   [7:0] base;
      begin
         base = sel ? `SLAVE_ADDR_ALT : `SLAVE_ADDR_DEFAULT;
         addr_match = (rx_byte[7:1] == base[7:1]);
      end
   endfunction

   // ****************************************
   // Transaction engine
   // ****************************************
   reg  [2:0]  state;
   reg  [7:0]  rx_shift;
   reg  [7:0]  tx_shift;
   reg  [3:0]  bit_cnt;
   reg         is_addr;
   reg         rw;
   reg  [1:0]  msg_pos;
   reg  [7:0]  data_hi;
   reg  [15:0] reg_addr;
   reg         tx_lo;
   reg         sda_drive;

   wire [15:0] rd_data;
   wire [7:0]  tx_byte = tx_lo ? rd_data[7:0] : rd_data[15:8];

   assign serial_data_out = 1'b0;
   assign serial_data_oe  = sda_drive;

   always @(posedge mclk)
   begin
      if (rst)
      begin
         state          <= S_IDLE;
         rx_shift       <= 8'h00;
         tx_shift       <= 8'h00;
         bit_cnt        <= `BIT_COUNT_ZERO;
         is_addr        <= 1'b0;
         rw             <= 1'b0;
         msg_pos        <= `MSG_ADDR_HI;
         data_hi        <= 8'h00;
         reg_addr       <= 16'h0000;
         tx_lo          <= 1'b0;
         sda_drive      <= 1'b0;
         reg_write      <= 1'b0;
         reg_write_addr <= 16'h0000;
         reg_write_data <= 16'h0000;
         bus_busy       <= 1'b0;
      end
      else
      begin
         reg_write <= 1'b0;
         if (start_det)
         begin
            state     <= S_RX;
            is_addr   <= 1'b1;
            bit_cnt   <= `BIT_COUNT_ZERO;
            sda_drive <= 1'b0;
            bus_busy  <= 1'b1;
         end
         else if (stop_det)
         begin
            state     <= S_IDLE;
            sda_drive <= 1'b0;
            bus_busy  <= 1'b0;
         end
         else
         begin
            bus_busy <= bus_busy & ~(scl_f & sda_f & (state == S_IDLE));
            case (state)
               S_RX:
               begin
                  if (scl_rise && bit_cnt != `BITS_PER_BYTE)
                  begin
                     rx_shift <= {rx_shift[6:0], sda_f};
                     bit_cnt  <= bit_cnt + `BIT_COUNT_ONE;
                  end
                  else if (scl_fall && bit_cnt == `BITS_PER_BYTE)
                  begin
                     bit_cnt <= `BIT_COUNT_ZERO;
                     if (is_addr)
                     begin
                        is_addr <= 1'b0;
                        state   <= S_IDLE;
                        if (addr_match(rx_shift, sel_f))
                        begin
                           sda_drive <= 1'b1;
                           rw        <= (rx_shift[0] == `DIR_READ);
                           msg_pos   <= `MSG_ADDR_HI;
                           tx_lo     <= 1'b0;
                           state     <= S_ACK;
                        end
                     end
                     else
                     begin
                        sda_drive <= 1'b1;
                        state     <= S_ACK;
                        msg_pos   <= msg_pos + 2'h1;
                        case (msg_pos)
                           `MSG_ADDR_HI: reg_addr[15:8] <= rx_shift;
                           `MSG_ADDR_LO: reg_addr[7:0]  <= rx_shift;
                           `MSG_DATA_HI: data_hi        <= rx_shift;
                           default:
                           begin
                              reg_write      <= 1'b1;
                              reg_write_addr <= reg_addr;
                              reg_write_data <= {data_hi, rx_shift};
                              reg_addr       <= reg_addr + `REG_ADDR_STEP;
                              msg_pos        <= `MSG_DATA_HI;
                           end
                        endcase
                     end
                  end
               end
               S_ACK, S_TXLOAD:
               begin
                  if (scl_fall)
                  begin
                     if (rw)
                     begin
                        sda_drive <= ~tx_byte[7];
                        tx_shift  <= {tx_byte[6:0], 1'b0};
                        bit_cnt   <= `BIT_COUNT_ONE;
                        state     <= S_TX;
                     end
                     else
                     begin
                        sda_drive <= 1'b0;
                        bit_cnt   <= `BIT_COUNT_ZERO;
                        state     <= S_RX;
                     end
                  end
               end
               S_TX:
               begin
                  if (scl_fall)
                  begin
                     if (bit_cnt != `BITS_PER_BYTE)
                     begin
                        sda_drive <= ~tx_shift[7];
                        tx_shift  <= {tx_shift[6:0], 1'b0};
                        bit_cnt   <= bit_cnt + `BIT_COUNT_ONE;
                     end
                     else
                     begin
                        sda_drive <= 1'b0;
                        state     <= S_MACK;
                     end
                  end
               end
               S_MACK:
               begin
                  if (scl_rise)
                  begin
                     if (sda_f)
                     begin
                        state <= S_IDLE;
                     end
                     else
                     begin
                        // After a low byte the address moves now so the store has the new word well before the next fall.
                        tx_lo <= ~tx_lo;
                        if (tx_lo)
                        begin
                           reg_addr <= reg_addr + `REG_ADDR_STEP;
                        end
                        state <= S_TXLOAD;
                     end
                  end
               end
               default:
               begin
                  state     <= S_IDLE;
                  sda_drive <= 1'b0;
               end
            endcase
         end
      end
   end

   // ****************************************
   // Register store
   // ****************************************
   reg_store u_store
   (
      .mclk  (mclk),
      .we    (reg_write),
      .waddr (reg_write_addr[`REG_INDEX_BITS-1:0]),
      .wdata (reg_write_data),
      .raddr (reg_addr[`REG_INDEX_BITS-1:0]),
      .rdata (rd_data)
   );

endmodule

// ---- tb/two_wire_register_slave_props.sv ----
`timescale 1ns/1ps
// ****
// Port checks for the bus slave.
// ****
module two_wire_register_slave_props
(
   input wire        mclk,
   input wire        rst,
   input wire        serial_clock_line,
   input wire        serial_data_in,
   input wire        serial_data_out,
   input wire        serial_data_oe,
   input wire        address_select_pin,
   input wire        reg_write,
   input wire [15:0] reg_write_addr,
   input wire [15:0] reg_write_data,
   input wire        bus_busy
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   chk_pull_only: assert property (!serial_data_out)
      else $error("data line driven high");
   // The clock pin passes a synchroniser, so the raw pin is looked at three cycles back.
   chk_oe_clk_low: assert property ($changed(serial_data_oe) |-> !$past(serial_clock_line, 3))
      else $error("data enable moved outside clock low");
   chk_oe_hold_high: assert property (serial_clock_line && $past(serial_clock_line, 4) |-> $stable(serial_data_oe))
      else $error("data enable moved while clock high");
   chk_write_pulse: assert property (reg_write |=> !reg_write)
      else $error("write strobe longer than one cycle");
   chk_write_busy: assert property (reg_write |-> bus_busy)
      else $error("write outside a transaction");
   chk_start_busy: assert property ($fell(serial_data_in) && serial_clock_line && $past(serial_clock_line)
      |-> ##[1:8] bus_busy)
      else $error("start not seen");
   chk_stop_idle: assert property ($rose(serial_data_in) && serial_clock_line && $past(serial_clock_line)
      |-> ##[1:8] !bus_busy)
      else $error("stop not seen");
   chk_oe_in_busy: assert property (serial_data_oe |-> bus_busy)
      else $error("data pulled while bus idle");
   chk_ack_word: assert property (reg_write |-> ##[0:6] serial_data_oe)
      else $error("written word not acknowledged");
endmodule

bind two_wire_register_slave two_wire_register_slave_props i_props
(
   .mclk, .rst, .serial_clock_line, .serial_data_in, .serial_data_out, .serial_data_oe,
   .address_select_pin, .reg_write, .reg_write_addr, .reg_write_data, .bus_busy
);

// ---- tb/bus_master.sv ----
`timescale 1ns/1ps
// ****
// Bus master model with a 125 ns clock.
// ****
module bus_master
(
   input wire       sda,
   output reg       scl,
   output reg       sdo,
   output reg [7:0] rx_val
);
   event got;
   reg   junk;

   // Only the master makes the clock, and it stops between frames.
   initial
   begin
      scl = 1'b1;
      sdo = 1'b1;
      rx_val = 8'h00;
   end

   // Edges are offset from the system clock so that no pin moves on its rising edge.
   task cyc(input b, input m, output r);
   begin
      #30 sdo = b;
      #32.5 scl = 1'b1;
      #15 r = sda;
      #16.25 sdo = m;
      #31.25 scl = m && !b;
   end
   endtask

   task start;
      cyc(1'b1, 1'b0, junk);
   endtask

   task stop;
      cyc(1'b0, 1'b1, junk);
   endtask

   task byte_io(input [7:0] d, input a, input w);
      integer   i;
      reg [7:0] q;
      reg       r;
   begin
      for (i = 7; i >= 0; i = i - 1)
         cyc(d[i], d[i], q[i]);
      cyc(a, a, r);
      rx_val = w ? {7'h00, r} : q;
      -> got;
   end
   endtask
endmodule

// ---- tb/two_wire_register_slave_test.sv ----
`timescale 1ns/1ps
// ****
// Self-checking bench for the two-wire register slave.
// ****
module two_wire_register_slave_test;
   reg         mclk;
   reg         rst;
   reg         sel;
   wire        scl;
   wire        sdo;
   wire        oe;
   wire        wr;
   wire [15:0] wa;
   wire [15:0] wd;
   wire [7:0]  rv;
   wire        sda;
   wire        busy;
   integer     failures;
   integer     total_checks;
   integer     k;
   reg [31:0]  wq[$];
   reg [7:0]   sq[$];
   reg [15:0]  a;
   reg [31:0]  d;
   reg [47:0]  msg;

   // Both parties only pull low; the pull-up gives the high level.
   assign sda = sdo & ~oe;

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   two_wire_register_slave i_dut
   (
      .mclk               (mclk),
      .rst                (rst),
      .serial_clock_line  (scl),
      .serial_data_in     (sda),
      .serial_data_out    (),
      .serial_data_oe     (oe),
      .address_select_pin (sel),
      .reg_write          (wr),
      .reg_write_addr     (wa),
      .reg_write_data     (wd),
      .bus_busy           (busy)
   );

   bus_master i_master
   (
      .sda    (sda),
      .scl    (scl),
      .sdo    (sdo),
      .rx_val (rv)
   );

   task chk(input [31:0] got, input [31:0] exp);
   begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
         failures = failures + 1;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   end
   endtask

   task test_done;
   begin
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask

   task wb(input [7:0] b);
   begin
      sq.push_back(8'h00);
      i_master.byte_io(b, 1'b1, 1'b1);
   end
   endtask

   task rb(input [7:0] e, input n);
   begin
      sq.push_back(e);
      i_master.byte_io(8'hFF, n, 1'b0);
   end
   endtask

   always @(posedge mclk)
      if (wr === 1'b1)
         chk({wa, wd}, wq.pop_front());
   // The port copy of the received byte settles after the event, so look a moment later.
   always @(i_master.got)
      #1 chk({24'h0, rv}, {24'h0, sq.pop_front()});

   initial
   begin
      #300000;
      failures = failures + 1;
      test_done;
   end

   initial
   begin
      failures = 0;
      total_checks = 0;
      rst = 1'b1;
      sel = 1'b0;
      void'($urandom(32'hAF17));
      a = $urandom;
      d = $urandom;
      msg = {a, d};
      repeat (12) @(negedge mclk);
      rst = 1'b0;
      repeat (10) @(negedge mclk);
      // Keeps every bus edge clear of the system clock's rising edge.
      #3.75;
      wq.push_back({a, d[31:16]});
      wq.push_back({a + 16'h0001, d[15:0]});
      i_master.start;
      wb(8'h90);
      chk({31'h0, busy}, 32'h00000001);
      for (k = 5; k >= 0; k = k - 1)
         wb(msg[8 * k +: 8]);
      i_master.stop;
      // Random read of both words, so the pointer must step between them.
      i_master.start;
      wb(8'h90);
      wb(a[15:8]);
      wb(a[7:0]);
      i_master.start;
      wb(8'h91);
      for (k = 3; k >= 0; k = k - 1)
         rb(d[8 * k +: 8], k == 0);
      i_master.stop;
      @(negedge mclk);
      sel = 1'b1;
      #253.75;
      i_master.start;
      wb(8'hBA);
      wb(a[15:8]);
      wb(a[7:0]);
      i_master.stop;
      i_master.start;
      wb(8'hBB);
      rb(d[31:24], 1'b0);
      rb(d[23:16], 1'b1);
      i_master.stop;
      for (k = 1; k >= 0; k = k - 1)
      begin
         @(negedge mclk);
         sel = k[0];
         #253.75;
         sq.push_back(8'h01);
         i_master.start;
         i_master.byte_io(k ? 8'h90 : 8'hBA, 1'b1, 1'b1);
         i_master.stop;
      end
      #1000;
      chk({31'h0, busy}, 32'h00000000);
      chk(wq.size() + sq.size(), 32'h00000000);
      test_done;
   end
endmodule
